// ===== src/aio_top.sv
// Interrupt output logic of the four-axis motion controller
`timescale 1ns/1ps
module aio_top #(
	parameter int N_AXES = aio_pkg::N_AXES,
	parameter int ERR_W = aio_pkg::ERR_W,
	parameter int EVT_W = aio_pkg::EVT_W
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// Cause sources, one bit per cause per axis
	input wire logic [N_AXES-1:0][ERR_W-1:0] ERR_SET_I,
	input wire logic [N_AXES-1:0][EVT_W-1:0] EVT_SET_I,
	input wire logic [N_AXES-1:0] STOP_EVT_I,
	input wire logic [N_AXES-1:0] PREREG_QUEUED_I,
	// Configuration bits
	input wire logic [N_AXES-1:0] INT_MASK_I,
	input wire logic [N_AXES-1:0] STOP_IRQ_EN_I,
	input wire logic [N_AXES-1:0] STOP_MODE_I,
	input wire logic [N_AXES-1:0] KEEP_MAIN_STATUS_ON_READ_I,
	input wire logic [N_AXES-1:0] KEEP_CAUSE_ON_READ_I,
	// Command and buffer
	input aio_pkg::aio_cmd_s CMD_I,
	input wire logic [aio_pkg::BUF_W-1:0] BUF_WDATA_I,
	output logic [aio_pkg::BUF_W-1:0] BUF_RDATA_O,
	output logic BUF_LOAD_O,
	// Main status read
	input wire logic MS_RD_I,
	input wire logic [1:0] MS_AXIS_I,
	output logic [N_AXES-1:0][aio_pkg::MS_W-1:0] MAIN_STATUS_WORD_O,
	// Event enable readback
	output logic [N_AXES-1:0][EVT_W-1:0] EVENT_ENABLE_REG_O,
	// Interrupt pin
	output logic INT_N_O
);
	logic [N_AXES-1:0][ERR_W-1:0] err_cause;
	logic [N_AXES-1:0][EVT_W-1:0] evt_cause;
	logic [N_AXES-1:0][EVT_W-1:0] evt_en;
	aio_pkg::aio_flags_s [N_AXES-1:0] flags;
	logic [N_AXES-1:0] err_rd, evt_rd, en_wr, ms_rd;
	logic [aio_pkg::BUF_W-1:0] buf_r, buf_nxt;
	logic load_r, load_nxt;

	// Decode a command against one axis
	function automatic logic cmd_hit(input aio_pkg::aio_cmd_s c, input logic [7:0] code,
		input int a);
		cmd_hit = c.valid && c.code == code && c.axis == 2'(a);
	endfunction

	always_comb
	begin
		for (int a = 0; a < N_AXES; a++)
		begin
			err_rd[a] = cmd_hit(CMD_I, aio_pkg::CMD_RD_ERR, a);
			evt_rd[a] = cmd_hit(CMD_I, aio_pkg::CMD_RD_EVT, a);
			en_wr[a] = cmd_hit(CMD_I, aio_pkg::CMD_WR_EVT_EN, a);
			ms_rd[a] = MS_RD_I && MS_AXIS_I == 2'(a);
		end
	end

	genvar g;
	generate
		for (g = 0; g < N_AXES; g++)
		begin : g_axis
			aio_axis_causes #(
				.ERR_W(ERR_W),
				.EVT_W(EVT_W)
			) u_axis (
				.clk_i(CORE_CLK_I),
				.resetn_i(RESETN_I),
				.err_set_i(ERR_SET_I[g]),
				.evt_set_i(EVT_SET_I[g]),
				.stop_evt_i(STOP_EVT_I[g]),
				.prereg_queued_i(PREREG_QUEUED_I[g]),
				.stop_en_i(STOP_IRQ_EN_I[g]),
				.stop_mode_i(STOP_MODE_I[g]),
				.keep_ms_i(KEEP_MAIN_STATUS_ON_READ_I[g]),
				.keep_cause_i(KEEP_CAUSE_ON_READ_I[g]),
				.err_rd_i(err_rd[g]),
				.evt_rd_i(evt_rd[g]),
				.ms_rd_i(ms_rd[g]),
				.en_wr_i(en_wr[g]),
				.en_data_i(BUF_WDATA_I[EVT_W-1:0]),
				.err_cause_o(err_cause[g]),
				.evt_cause_o(evt_cause[g]),
				.evt_en_o(evt_en[g]),
				.flags_o(flags[g])
			);
		end
	endgenerate

	// Buffer load from cause registers
	always_comb
	begin
		buf_nxt = buf_r;
		load_nxt = 1'b0;
		if (CMD_I.valid && CMD_I.code == aio_pkg::CMD_RD_ERR)
		begin
			buf_nxt = aio_pkg::BUF_W'(err_cause[CMD_I.axis]);
			load_nxt = 1'b1;
		end
		else if (CMD_I.valid && CMD_I.code == aio_pkg::CMD_RD_EVT)
		begin
			buf_nxt = aio_pkg::BUF_W'(evt_cause[CMD_I.axis]);
			load_nxt = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (!RESETN_I)
		begin
			buf_r <= aio_pkg::BUF_RST;
			load_r <= 1'b0;
		end
		else
		begin
			buf_r <= buf_nxt;
			load_r <= load_nxt;
		end
	end

	assign BUF_RDATA_O = buf_r;
	assign BUF_LOAD_O = load_r;
	assign EVENT_ENABLE_REG_O = evt_en;

	// Main status summary bits
	always_comb
	begin
		for (int a = 0; a < N_AXES; a++)
		begin
			MAIN_STATUS_WORD_O[a] = '0;
			MAIN_STATUS_WORD_O[a][aio_pkg::MS_STOP_BIT] = flags[a].stop;
			MAIN_STATUS_WORD_O[a][aio_pkg::MS_ERR_BIT] = flags[a].err;
			MAIN_STATUS_WORD_O[a][aio_pkg::MS_EVT_BIT] = flags[a].evt;
		end
	end

	aio_int_out #(
		.N_AXES(N_AXES)
	) u_int (
		.clk_i(CORE_CLK_I),
		.resetn_i(RESETN_I),
		.flags_i(flags),
		.mask_i(INT_MASK_I),
		.int_n_o(INT_N_O)
	);

	// Helper terms for checks
	logic pending0;
	logic cmd_err0, cmd_evt0, cmd_en0;
	assign pending0 = |flags[0];
	assign cmd_err0 = cmd_hit(CMD_I, aio_pkg::CMD_RD_ERR, 0);
	assign cmd_evt0 = cmd_hit(CMD_I, aio_pkg::CMD_RD_EVT, 0);
	assign cmd_en0 = cmd_hit(CMD_I, aio_pkg::CMD_WR_EVT_EN, 0);

	a_unused_bit_zero: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		err_cause[0][aio_pkg::ERR_UNUSED_BIT] == 1'b0)
		else $error("Reserved error cause bit set");

	a_error_always_flags: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		(ERR_SET_I[0] & aio_pkg::ERR_VALID_MASK) != '0
		|=> flags[0].err && MAIN_STATUS_WORD_O[0][aio_pkg::MS_ERR_BIT])
		else $error("Error cause did not set error flag");

	a_event_gated_off: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		evt_cause[0] == '0 && (EVT_SET_I[0] & evt_en[0]) == '0
		|=> evt_cause[0] == '0)
		else $error("Disabled event reached cause register");

	a_event_gated_on: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		(EVT_SET_I[0] & evt_en[0]) != '0 |=> flags[0].evt)
		else $error("Enabled event did not set event flag");

	a_stop_withheld: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		!flags[0].stop && STOP_MODE_I[0] && PREREG_QUEUED_I[0]
		|=> !flags[0].stop)
		else $error("Stop interrupt raised with next data queued");

	a_stop_raised: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		STOP_EVT_I[0] && STOP_IRQ_EN_I[0] && !(STOP_MODE_I[0] && PREREG_QUEUED_I[0])
		|=> flags[0].stop ##1 ($past(INT_MASK_I[0]) || !INT_N_O))
		else $error("Enabled stop did not set stop flag");

	a_pin_follows_pending: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		pending0 && !INT_MASK_I[0] |=> !INT_N_O)
		else $error("Pin released while causes pending");

	a_pin_idle_high: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		(flags == '0) |=> INT_N_O)
		else $error("Pin low with nothing pending");

	a_mask_holds_high: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		INT_MASK_I == '1 |=> INT_N_O)
		else $error("Masked pin went low");

	a_unmask_drives_low: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		$fell(INT_MASK_I[0]) && pending0 |=> !INT_N_O)
		else $error("Unmask with pending cause left pin high");

	a_err_read_clears: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		cmd_err0 && !KEEP_CAUSE_ON_READ_I[0] && ERR_SET_I[0] == '0
		|=> err_cause[0] == '0 && !flags[0].err)
		else $error("Error cause read did not clear");

	a_keep_on_read: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		cmd_evt0 && KEEP_CAUSE_ON_READ_I[0] && evt_cause[0] != '0
		|=> evt_cause[0] != '0)
		else $error("Kept event cause was cleared");

	a_ms_read_clears: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		MS_RD_I && MS_AXIS_I == 2'h0 && !KEEP_MAIN_STATUS_ON_READ_I[0] && !STOP_EVT_I[0]
		|=> !flags[0].stop)
		else $error("Main status read did not clear stop flag");

	a_buf_copies_err: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		cmd_err0 |=> BUF_LOAD_O && BUF_RDATA_O == aio_pkg::BUF_W'($past(err_cause[0])))
		else $error("Buffer does not hold error causes");

	a_buf_copies_evt: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		cmd_evt0 |=> BUF_RDATA_O == aio_pkg::BUF_W'($past(evt_cause[0])))
		else $error("Buffer does not hold event causes");

	a_enable_written: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		cmd_en0 |=> evt_en[0] == $past(BUF_WDATA_I[EVT_W-1:0]))
		else $error("Event enable not written from buffer");

	a_no_spurious_load: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		!(CMD_I.valid && (CMD_I.code == aio_pkg::CMD_RD_ERR || CMD_I.code == aio_pkg::CMD_RD_EVT))
		|=> !BUF_LOAD_O)
		else $error("Buffer loaded without a cause read");

	a_stop_disabled: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		!flags[0].stop && !STOP_IRQ_EN_I[0] |=> !flags[0].stop)
		else $error("Stop flag set while stop interrupt disabled");

	a_evt_read_clears: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		cmd_evt0 && !KEEP_CAUSE_ON_READ_I[0] && (EVT_SET_I[0] & evt_en[0]) == '0
		|=> evt_cause[0] == '0 && !flags[0].evt)
		else $error("Event cause read did not clear");

	a_keep_ms_read: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		MS_RD_I && MS_AXIS_I == 2'h0 && KEEP_MAIN_STATUS_ON_READ_I[0] && flags[0].stop
		|=> flags[0].stop)
		else $error("Kept stop flag was cleared");

	a_status_spare_zero: assert property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		(MAIN_STATUS_WORD_O[0] & 8'hCB) == 8'h00)
		else $error("Spare main status bit set");

	c_pin_asserted: cover property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		INT_N_O ##1 !INT_N_O);

	c_read_releases: cover property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		!INT_N_O && cmd_err0 ##2 INT_N_O);

	c_unmask_pending: cover property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		$fell(INT_MASK_I[0]) && pending0);

	c_stop_cleared: cover property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		flags[0].stop ##1 !flags[0].stop);

	c_cause_kept: cover property (
		@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		KEEP_CAUSE_ON_READ_I[0] && cmd_evt0 && pending0 ##1 pending0);
endmodule // aio_top

// ===== src/aio_pkg.sv
// Shared constants and types for the axis interrupt output block
package aio_pkg;
	localparam int N_AXES = 4;
	localparam int ERR_W = 18;
	localparam int EVT_W = 20;
	localparam int BUF_W = 32;
	localparam int MS_W = 8;
	// Main status summary bit positions
	localparam int MS_STOP_BIT = 2;
	localparam int MS_ERR_BIT = 4;
	localparam int MS_EVT_BIT = 5;
	// Environment and mode bit positions carried by the config ports
	localparam int ENV1_MASK_BIT = 29;
	localparam int ENV2_STOP_EN_BIT = 27;
	localparam int ENV5_KEEP_MS_BIT = 22;
	localparam int ENV5_KEEP_CAUSE_BIT = 23;
	localparam int PRMD_STOP_MODE_BIT = 7;
	// Error cause bit that always reads zero
	localparam int ERR_UNUSED_BIT = 11;
	localparam logic [ERR_W-1:0] ERR_VALID_MASK = 18'h3F7FF;
	// Command codes
	localparam logic [7:0] CMD_RD_ERR = 8'hF2;
	localparam logic [7:0] CMD_RD_EVT = 8'hF3;
	localparam logic [7:0] CMD_WR_EVT_EN = 8'hAC;
	// Reset values
	localparam logic [ERR_W-1:0] ERR_RST = 18'h00000;
	localparam logic [EVT_W-1:0] EVT_RST = 20'h00000;
	localparam logic [BUF_W-1:0] BUF_RST = 32'h00000000;

	typedef struct packed {
		logic valid;
		logic [1:0] axis;
		logic [7:0] code;
	} aio_cmd_s;

	typedef struct packed {
		logic evt;
		logic err;
		logic stop;
	} aio_flags_s;
endpackage

// ===== src/aio_axis_causes.sv
// Per-axis cause registers, event enable and summary flags
`timescale 1ns/1ps
module aio_axis_causes #(
	parameter int ERR_W = 18,
	parameter int EVT_W = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Cause sources
	input wire logic [ERR_W-1:0] err_set_i,
	input wire logic [EVT_W-1:0] evt_set_i,
	input wire logic stop_evt_i,
	input wire logic prereg_queued_i,
	// Configuration
	input wire logic stop_en_i,
	input wire logic stop_mode_i,
	input wire logic keep_ms_i,
	input wire logic keep_cause_i,
	// Access strobes
	input wire logic err_rd_i,
	input wire logic evt_rd_i,
	input wire logic ms_rd_i,
	input wire logic en_wr_i,
	input wire logic [EVT_W-1:0] en_data_i,
	// State
	output logic [ERR_W-1:0] err_cause_o,
	output logic [EVT_W-1:0] evt_cause_o,
	output logic [EVT_W-1:0] evt_en_o,
	output aio_pkg::aio_flags_s flags_o
);
	logic [ERR_W-1:0] err_r, err_nxt;
	logic [EVT_W-1:0] evt_r, evt_nxt, en_r, en_nxt;
	logic stop_r, stop_nxt;

	always_comb
	begin
		err_nxt = err_r;
		evt_nxt = evt_r;
		en_nxt = en_r;
		stop_nxt = stop_r;
		if (en_wr_i)
			en_nxt = en_data_i;
		if (err_rd_i && !keep_cause_i)
			err_nxt = '0;
		if (evt_rd_i && !keep_cause_i)
			evt_nxt = '0;
		if (ms_rd_i && !keep_ms_i)
			stop_nxt = 1'b0;
		// Sets win over clears
		err_nxt = (err_nxt | err_set_i) & aio_pkg::ERR_VALID_MASK;
		evt_nxt = evt_nxt | (evt_set_i & en_r);
		if (stop_evt_i && stop_en_i && !(stop_mode_i && prereg_queued_i))
			stop_nxt = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			err_r <= aio_pkg::ERR_RST;
			evt_r <= aio_pkg::EVT_RST;
			en_r <= aio_pkg::EVT_RST;
			stop_r <= 1'b0;
		end
		else
		begin
			err_r <= err_nxt;
			evt_r <= evt_nxt;
			en_r <= en_nxt;
			stop_r <= stop_nxt;
		end
	end

	assign err_cause_o = err_r;
	assign evt_cause_o = evt_r;
	assign evt_en_o = en_r;
	assign flags_o.stop = stop_r;
	assign flags_o.err = |err_r;
	assign flags_o.evt = |evt_r;
endmodule // aio_axis_causes

// ===== src/aio_int_out.sv
// Shared active-low interrupt pin driver
`timescale 1ns/1ps
module aio_int_out #(
	parameter int N_AXES = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Per-axis flags and masks
	input aio_pkg::aio_flags_s [N_AXES-1:0] flags_i,
	input wire logic [N_AXES-1:0] mask_i,
	// Pin
	output logic int_n_o
);
	logic int_n_r, int_n_nxt;

	always_comb
	begin
		int_n_nxt = 1'b1;
		for (int a = 0; a < N_AXES; a++)
			if (!mask_i[a] && (|flags_i[a]))
				int_n_nxt = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			int_n_r <= 1'b1;
		else
			int_n_r <= int_n_nxt;
	end

	assign int_n_o = int_n_r;
endmodule // aio_int_out

// ===== testbench/aio_host_model.sv
// Host CPU model: command driver and interrupt service routine
`timescale 1ns/1ps
module aio_host_model (
	// Clock, pin and main status words
	input wire logic clk_i,
	input wire logic int_n_i,
	input wire logic [3:0][7:0] ms_i,
	// Host access
	output aio_pkg::aio_cmd_s cmd_o,
	output logic [31:0] wdata_o,
	output logic ms_rd_o,
	output logic [1:0] ms_axis_o
);
	initial
	begin
		cmd_o = '0;
		wdata_o = '0;
		ms_rd_o = 1'b0;
		ms_axis_o = 2'h0;
	end
	// One-cycle command strobe
	task automatic cmd(input logic [1:0] ax, input logic [7:0] code);
		@(negedge clk_i);
		cmd_o = {1'b1, ax, code};
		@(negedge clk_i);
		cmd_o = '0;
	endtask
	// One-cycle status read, axis select driven to the complement of ax afterwards
	task automatic ms_rd(input logic [1:0] ax);
		@(negedge clk_i);
		ms_rd_o = 1'b1;
		ms_axis_o = ax;
		@(negedge clk_i);
		ms_rd_o = 1'b0;
		ms_axis_o = ~ax;
	endtask
	// Buffer contents seen by the block
	task automatic set_wdata(input logic [31:0] d);
		wdata_o = d;
	endtask
	// Interrupt handler
	task automatic service();
		logic [31:0] saved;
		saved = wdata_o;
		wdata_o = '0;
		for (int p = 0; p < 4 && int_n_i === 1'b0; p++)
		begin
			for (int ax = 0; ax < 4; ax++)
			begin
				if (ms_i[ax][aio_pkg::MS_ERR_BIT] === 1'b1)
					cmd(ax[1:0], aio_pkg::CMD_RD_ERR);
				if (ms_i[ax][aio_pkg::MS_EVT_BIT] === 1'b1)
					cmd(ax[1:0], aio_pkg::CMD_RD_EVT);
				if (ms_i[ax][aio_pkg::MS_STOP_BIT] === 1'b1)
					ms_rd(ax[1:0]);
			end
			repeat (2) @(negedge clk_i);
		end
		wdata_o = saved;
	endtask
endmodule // aio_host_model

// ===== testbench/test_axis_interrupt_output.sv
// Self-checking bench for the axis interrupt output block
`timescale 1ns/1ps
module test_axis_interrupt_output;
	typedef struct packed {
		logic [1:0] ax;
		logic [17:0] err;
		logic [19:0] evt;
		logic [19:0] en;
		logic [17:0] xerr;
		logic [19:0] xevt;
	} aio_row_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0][17:0] err_set = '0;
	logic [3:0][19:0] evt_set = '0;
	logic [3:0] stop_evt = '0;
	logic [3:0] queued = '0;
	logic [3:0] mask = '0;
	logic [3:0] stop_en = '0;
	logic [3:0] stop_mode = '0;
	logic [3:0] keep_ms = '0;
	logic [3:0] keep_cause = '0;
	aio_pkg::aio_cmd_s cmd;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic load;
	logic ms_rd;
	logic [1:0] ms_axis;
	logic [3:0][7:0] ms;
	logic [3:0][19:0] en_rb;
	logic int_n;
	int miscompares = 0;
	int cmp_count = 0;
	aio_row_s rows [5] = '{
		'{2'h0, 18'h00820, 20'h00000, 20'h00000, 18'h00020, 20'h00000},
		'{2'h1, 18'h00000, 20'h80001, 20'h80001, 18'h00000, 20'h80001},
		'{2'h2, 18'h00000, 20'h00F00, 20'h00300, 18'h00000, 20'h00300},
		'{2'h3, 18'h3F7FF, 20'hFFFFF, 20'h00000, 18'h3F7FF, 20'h00000},
		'{2'h0, 18'h00000, 20'h00010, 20'h00000, 18'h00000, 20'h00000}
	};
	initial
	begin
		forever #25 clk = ~clk;
	end
	aio_top u_dut (
		.CORE_CLK_I(clk), .RESETN_I(rst_n), .ERR_SET_I(err_set), .EVT_SET_I(evt_set),
		.STOP_EVT_I(stop_evt), .PREREG_QUEUED_I(queued), .INT_MASK_I(mask),
		.STOP_IRQ_EN_I(stop_en), .STOP_MODE_I(stop_mode),
		.KEEP_MAIN_STATUS_ON_READ_I(keep_ms), .KEEP_CAUSE_ON_READ_I(keep_cause),
		.CMD_I(cmd), .BUF_WDATA_I(wdata), .BUF_RDATA_O(rdata), .BUF_LOAD_O(load),
		.MS_RD_I(ms_rd), .MS_AXIS_I(ms_axis), .MAIN_STATUS_WORD_O(ms),
		.EVENT_ENABLE_REG_O(en_rb), .INT_N_O(int_n)
	);
	aio_host_model u_host (
		.clk_i(clk), .int_n_i(int_n), .ms_i(ms), .cmd_o(cmd), .wdata_o(wdata),
		.ms_rd_o(ms_rd), .ms_axis_o(ms_axis)
	);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One-cycle cause pulse, returns once the pin has had time to follow
	task automatic pulse(input int ax, input logic [17:0] e, input logic [19:0] v,
		input logic s);
		@(negedge clk);
		err_set[ax] = e;
		evt_set[ax] = v;
		stop_evt[ax] = s;
		@(negedge clk);
		err_set[ax] = '0;
		evt_set[ax] = '0;
		stop_evt[ax] = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		test_done();
	end
	initial
	begin
		repeat (20) @(negedge clk);
		chk("pin in reset", {31'h0, int_n}, 32'h1);
		chk("status in reset", ms, 32'h0);
		chk("buffer in reset", rdata, 32'h0);
		rst_n = 1'b1;
		foreach (rows[i])
		begin
			u_host.set_wdata({12'h0, rows[i].en});
			u_host.cmd(rows[i].ax, aio_pkg::CMD_WR_EVT_EN);
			@(negedge clk);
			chk("enable", {12'h0, en_rb[rows[i].ax]}, {12'h0, rows[i].en});
			pulse(rows[i].ax, rows[i].err, rows[i].evt, 1'b0);
			chk("pin set", {31'h0, int_n}, {31'h0, ~(|rows[i].xerr | |rows[i].xevt)});
			chk("err flag", {31'h0, ms[rows[i].ax][4]}, {31'h0, |rows[i].xerr});
			chk("evt flag", {31'h0, ms[rows[i].ax][5]}, {31'h0, |rows[i].xevt});
			u_host.cmd(rows[i].ax, aio_pkg::CMD_RD_ERR);
			chk("load", {31'h0, load}, 32'h1);
			chk("err cause", rdata, {14'h0, rows[i].xerr});
			u_host.cmd(rows[i].ax, aio_pkg::CMD_RD_EVT);
			chk("evt cause", rdata, {12'h0, rows[i].xevt});
			@(negedge clk);
			chk("pin clear", {31'h0, int_n}, 32'h1);
			chk("status clear", {24'h0, ms[rows[i].ax]}, 32'h0);
		end
		stop_en[0] = 1'b1;
		stop_mode[0] = 1'b1;
		queued[0] = 1'b1;
		pulse(0, '0, '0, 1'b1);
		chk("stop withheld", {31'h0, ms[0][2]}, 32'h0);
		queued[0] = 1'b0;
		pulse(0, '0, '0, 1'b1);
		chk("stop flag", {24'h0, ms[0]}, 32'h4);
		chk("stop pin", {31'h0, int_n}, 32'h0);
		keep_ms[0] = 1'b1;
		u_host.ms_rd(2'h0);
		repeat (2) @(negedge clk);
		chk("stop kept", {31'h0, ms[0][2]}, 32'h1);
		keep_ms[0] = 1'b0;
		u_host.ms_rd(2'h0);
		repeat (2) @(negedge clk);
		chk("stop cleared", {31'h0, int_n}, 32'h1);
		stop_en[0] = 1'b0;
		pulse(0, '0, '0, 1'b1);
		chk("stop disabled", {31'h0, ms[0][2]}, 32'h0);
		mask[0] = 1'b1;
		pulse(0, 18'h00001, '0, 1'b0);
		chk("masked flag", {31'h0, ms[0][4]}, 32'h1);
		chk("masked pin", {31'h0, int_n}, 32'h1);
		@(negedge clk);
		mask[0] = 1'b0;
		repeat (2) @(negedge clk);
		chk("unmasked pin", {31'h0, int_n}, 32'h0);
		pulse(2, 18'h00002, '0, 1'b0);
		keep_cause[2] = 1'b1;
		u_host.cmd(2'h0, aio_pkg::CMD_RD_ERR);
		u_host.cmd(2'h2, aio_pkg::CMD_RD_ERR);
		@(negedge clk);
		chk("kept cause", rdata, 32'h2);
		@(negedge clk);
		chk("pin held", {31'h0, int_n}, 32'h0);
		chk("kept flag", {31'h0, ms[2][4]}, 32'h1);
		keep_cause[2] = 1'b0;
		u_host.cmd(2'h2, 8'h00);
		chk("unknown code", {31'h0, load}, 32'h0);
		chk("buffer kept", rdata, 32'h2);
		u_host.set_wdata(32'h00000001);
		u_host.cmd(2'h0, aio_pkg::CMD_WR_EVT_EN);
		pulse(0, '0, 20'h00001, 1'b0);
		keep_cause[0] = 1'b1;
		u_host.cmd(2'h0, aio_pkg::CMD_RD_EVT);
		chk("kept evt cause", rdata, 32'h1);
		@(negedge clk);
		chk("kept evt flag", {31'h0, ms[0][5]}, 32'h1);
		keep_cause[0] = 1'b0;
		u_host.set_wdata(32'h0000ABCD);
		pulse(1, '0, 20'h00001, 1'b0);
		pulse(3, 18'h10000, '0, 1'b0);
		u_host.service();
		@(negedge clk);
		chk("serviced pin", {31'h0, int_n}, 32'h1);
		chk("serviced status", ms, 32'h0);
		chk("buffer restored", wdata, 32'h0000ABCD);
		test_done();
	end
endmodule // test_axis_interrupt_output
